// ---- src/ucpf_consts.svh ----
// Constants for the per-channel pin function logic
// How it works
// R1 - Multi-function pin shows exactly one selected function
// R2 - User output two low when control bit three set
// R3 - Control bit three resets to one
// R4 - Baud clock mode outputs sixteen-times clock, active low
// R5 - Receive-ready mode gives active-low data-available indication
// R6 - Far end idles receive input high
// R7 - Send-request and terminal-ready outputs active low, general purpose
// R8 - Modem inputs active low, readable, no datapath effect
// R9 - Transmit pin carries framed outgoing characters
// R10 - Select zero user, one baud, two ready, three user
`ifndef UCPF_CONSTS_SVH
`define UCPF_CONSTS_SVH
`define UCPF_SEL_LSB      1
`define UCPF_SEL_MSB      2
`define UCPF_MCR_OP2_BIT  3
`define UCPF_MCR_DTR_BIT  0
`define UCPF_MCR_RTS_BIT  1
`define UCPF_MCR_RESET    8'h08
`define UCPF_AFR_RESET    8'h00
`define UCPF_TX_IDLE      1'b1
`define UCPF_SYNC_STAGES  2
`endif

// ---- src/ucpf_pkg.sv ----
// Types for the per-channel pin function logic
package ucpf_pkg;
  // Function select codes of the multi-function pin
  typedef enum logic [1:0] {
    UCPF_FN_USER  = 2'h0,
    UCPF_FN_BAUD  = 2'h1,
    UCPF_FN_READY = 2'h2,
    UCPF_FN_SPARE = 2'h3
  } ucpf_fn_t;
endpackage

// ---- src/ucpf_mf_sel.sv ----
// Multi-function output selector for one channel
`timescale 1ns/1ns
`include "ucpf_consts.svh"
module ucpf_mf_sel (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic [7:0] alternate_function_reg,
  input  wire logic [7:0] modem_control_reg,
  input  wire logic       baud16,
  input  wire logic       rx_avail,
  output logic            multi_function_out_n
);
  import ucpf_pkg::*;

  // Field decode, used by both the mux and the user-level check
  function automatic ucpf_fn_t fn_decode(input logic [7:0] a);
    logic [1:0] s;
    s = a[`UCPF_SEL_MSB:`UCPF_SEL_LSB];
    case (s)
      2'h1:    fn_decode = UCPF_FN_BAUD;
      2'h2:    fn_decode = UCPF_FN_READY;
      default: fn_decode = UCPF_FN_USER; // R10
    endcase
  endfunction

  logic mf_r;   // Registered pin level
  logic mf_nxt; // Next pin level

  // Pick one function for the pin
  always_comb begin
    case (fn_decode(alternate_function_reg))
      UCPF_FN_BAUD:  mf_nxt = ~baud16;              // R4
      UCPF_FN_READY: mf_nxt = ~rx_avail;            // R5
      default:       mf_nxt = ~modem_control_reg[`UCPF_MCR_OP2_BIT]; // R1 R2
    endcase
  end

  // Register the pin; low in reset, as control bit three resets to one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mf_r <= 1'b0; // Reset control bit is one, so pin is low
    end else if (clk_en) begin
      mf_r <= mf_nxt;
    end
  end

  assign multi_function_out_n = mf_r;

  a_user_level: assert property (@(posedge clk) disable iff (!reset_n) // R2
    clk_en && fn_decode(alternate_function_reg) == UCPF_FN_USER
    |=> multi_function_out_n == ~$past(modem_control_reg[`UCPF_MCR_OP2_BIT]))
    else $error("user output level wrong");
  a_ready_level: assert property (@(posedge clk) disable iff (!reset_n) // R5
    clk_en && alternate_function_reg[2:1] == 2'h2 |=> multi_function_out_n == ~$past(rx_avail))
    else $error("ready level wrong");
  a_baud_level: assert property (@(posedge clk) disable iff (!reset_n) // R4
    clk_en && alternate_function_reg[2:1] == 2'h1 |=> multi_function_out_n == ~$past(baud16))
    else $error("baud level wrong");
endmodule

// ---- src/ucpf_channel.sv ----
// Pin-level logic of one serial channel
`timescale 1ns/1ns
`include "ucpf_consts.svh"
module ucpf_channel #(
  parameter int DATA_W = 8
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        afr_we,
  input  wire logic [7:0]  afr_wdata,
  input  wire logic        mcr_we,
  input  wire logic [7:0]  mcr_wdata,
  input  wire logic        baud16,
  input  wire logic        rx_avail,
  input  wire logic        tx_bit,
  input  wire logic        serial_in,
  input  wire logic        clear_send_n,
  input  wire logic        set_ready_n,
  input  wire logic        carrier_detect_n,
  output logic             multi_function_out_n,
  output logic             serial_out,
  output logic             request_send_n,
  output logic             terminal_ready_n,
  output logic             rx_bit,
  output logic [2:0]       modem_in_status,
  output logic [7:0]       afr_q,
  output logic [7:0]       mcr_q
);
  import ucpf_pkg::*;

  // Width check: registers are byte wide
  if (DATA_W != 8) begin : g_bad_width
    $error("DATA_W must be 8");
  end

  logic [7:0] afr_r, afr_nxt;   // Alternate function register
  logic [7:0] mcr_r, mcr_nxt;   // Modem control register
  logic       tx_r, tx_nxt;     // Transmit pin
  logic       rts_r, rts_nxt;   // Send-request pin
  logic       dtr_r, dtr_nxt;   // Terminal-ready pin
  logic       rx_r, rx_nxt;     // Sampled receive line
  logic [2:0] mi_r, mi_nxt;     // Sampled modem inputs, active high
  logic [2:0] modem_pins_n;     // Modem input pins, {cd,dsr,cts}
  logic [2:0] modem_active;     // Same pins, turned active high

  // Gather the active-low modem inputs in one bus
  assign modem_pins_n = {carrier_detect_n, set_ready_n, clear_send_n};

  // One inverter per modem input; levels are status only
  for (genvar gi = 0; gi < 3; gi++) begin : g_modem_in
    assign modem_active[gi] = ~modem_pins_n[gi]; // R8
  end

  // Next values for control registers and pins
  always_comb begin
    afr_nxt = afr_we ? afr_wdata : afr_r;
    mcr_nxt = mcr_we ? mcr_wdata : mcr_r;
    tx_nxt  = tx_bit;                               // R9
    rts_nxt = ~mcr_r[`UCPF_MCR_RTS_BIT];            // R7
    dtr_nxt = ~mcr_r[`UCPF_MCR_DTR_BIT];            // R7
    rx_nxt  = serial_in;                            // R6
    // Status only; never steers the datapath
    mi_nxt  = modem_active;                         // R8
  end

  // Registers, frozen when clock enable is low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      afr_r <= `UCPF_AFR_RESET;
      mcr_r <= `UCPF_MCR_RESET; // R3
      tx_r  <= `UCPF_TX_IDLE;   // Line held idle during reset
      rts_r <= 1'b1;
      dtr_r <= 1'b1;
      rx_r  <= 1'b1;
      mi_r  <= 3'h0;
    end else if (clk_en) begin
      afr_r <= afr_nxt;
      mcr_r <= mcr_nxt;
      tx_r  <= tx_nxt;
      rts_r <= rts_nxt;
      dtr_r <= dtr_nxt;
      rx_r  <= rx_nxt;
      mi_r  <= mi_nxt;
    end
  end

  // Pin selector reads live registers, one extra cycle of latency
  ucpf_mf_sel u_mf (
    .clk                  (clk),
    .reset_n              (reset_n),
    .clk_en               (clk_en),
    .alternate_function_reg                  (afr_r),
    .modem_control_reg                  (mcr_r),
    .baud16               (baud16),
    .rx_avail             (rx_avail),
    .multi_function_out_n (multi_function_out_n)
  );

  assign serial_out       = tx_r;
  assign request_send_n   = rts_r;
  assign terminal_ready_n = dtr_r;
  assign rx_bit           = rx_r;
  assign modem_in_status  = mi_r;
  assign afr_q            = afr_r;
  assign mcr_q            = mcr_r;

  // Reset seen on two edges running; defaults must then show
  sequence s_reset_held;
    !reset_n ##1 !reset_n;
  endsequence

  // A write taken while the block runs
  sequence s_afr_taken;
    clk_en && afr_we;
  endsequence

  // Same for the modem control register
  sequence s_mcr_taken;
    clk_en && mcr_we;
  endsequence

  // Control register comes out of reset with bit three set
  a_mcr_reset: assert property (@(posedge clk) // R3
    !reset_n
    |=> mcr_q == `UCPF_MCR_RESET)
    else $error("control reset value wrong");

  // Function select resets to user output two
  a_afr_reset: assert property (@(posedge clk) // R1
    !reset_n
    |=> afr_q == `UCPF_AFR_RESET)
    else $error("function reset value wrong");

  // Transmit line idles high through reset
  a_tx_reset: assert property (@(posedge clk) // R9
    !reset_n
    |=> serial_out == `UCPF_TX_IDLE)
    else $error("transmit reset level wrong");

  // Modem outputs inactive (high) after reset
  a_modem_reset: assert property (@(posedge clk) // R7
    !reset_n
    |=> request_send_n && terminal_ready_n)
    else $error("modem output reset level wrong");

  // Receive copy shows an idle line after reset
  a_rx_reset: assert property (@(posedge clk) // R6
    !reset_n
    |=> rx_bit == 1'b1)
    else $error("receive reset level wrong");

  // No modem input is reported active after reset
  a_status_reset: assert property (@(posedge clk) // R8
    !reset_n
    |=> modem_in_status == 3'h0)
    else $error("status reset value wrong");

  // Pin low while reset holds, since bit three resets to one
  a_reset_pin: assert property (@(posedge clk) // R3
    s_reset_held
    |-> multi_function_out_n == 1'b0)
    else $error("pin not low after reset");

  // Send-request pin is the inverse of its control bit
  a_rts_follow: assert property (@(posedge clk) disable iff (!reset_n) // R7
    clk_en
    |=> request_send_n == ~$past(mcr_r[`UCPF_MCR_RTS_BIT]))
    else $error("send-request level wrong");

  // Terminal-ready pin is the inverse of its control bit
  a_dtr_follow: assert property (@(posedge clk) disable iff (!reset_n) // R7
    clk_en
    |=> terminal_ready_n == ~$past(mcr_r[`UCPF_MCR_DTR_BIT]))
    else $error("terminal-ready level wrong");

  // Transmit pin carries the transmitter's bit one edge later
  a_tx_follow: assert property (@(posedge clk) disable iff (!reset_n) // R9
    clk_en
    |=> serial_out == $past(tx_bit))
    else $error("transmit pin wrong");

  // Receive copy follows the line one edge later
  a_rx_follow: assert property (@(posedge clk) disable iff (!reset_n) // R6
    clk_en
    |=> rx_bit == $past(serial_in))
    else $error("receive copy wrong");

  // Clear-to-send reported active high
  a_status_in: assert property (@(posedge clk) disable iff (!reset_n) // R8
    clk_en
    |=> modem_in_status[0] == ~$past(clear_send_n))
    else $error("modem status wrong");

  // Data-set-ready reported active high
  a_status_dsr: assert property (@(posedge clk) disable iff (!reset_n) // R8
    clk_en
    |=> modem_in_status[1] == ~$past(set_ready_n))
    else $error("set-ready status wrong");

  // Carrier-detect reported active high
  a_status_cd: assert property (@(posedge clk) disable iff (!reset_n) // R8
    clk_en
    |=> modem_in_status[2] == ~$past(carrier_detect_n))
    else $error("carrier status wrong");

  // A taken write lands in the function register
  a_afr_write: assert property (@(posedge clk) disable iff (!reset_n) // R1
    s_afr_taken
    |=> afr_q == $past(afr_wdata))
    else $error("function write lost");

  // A taken write lands in the modem control register
  a_mcr_write: assert property (@(posedge clk) disable iff (!reset_n) // R2
    s_mcr_taken
    |=> mcr_q == $past(mcr_wdata))
    else $error("control write lost");

  // Function register holds without a taken write
  a_afr_hold: assert property (@(posedge clk) disable iff (!reset_n) // R1
    !(clk_en && afr_we)
    |=> $stable(afr_q))
    else $error("function register drifted");

  // Modem inputs never disturb the modem control register
  a_mcr_hold: assert property (@(posedge clk) disable iff (!reset_n) // R8
    !(clk_en && mcr_we)
    |=> $stable(mcr_q))
    else $error("control register drifted");

  // Clock enable low freezes the multi-function pin
  a_freeze_pin: assert property (@(posedge clk) disable iff (!reset_n) // R1
    !clk_en
    |=> $stable(multi_function_out_n))
    else $error("pin moved while frozen");

  // Clock enable low freezes the line and modem pins
  a_freeze_line: assert property (@(posedge clk) disable iff (!reset_n) // R7
    !clk_en
    |=> $stable({serial_out, request_send_n, terminal_ready_n, rx_bit}))
    else $error("line pins moved while frozen");

  // Spare select code behaves as user output two
  a_spare_user: assert property (@(posedge clk) disable iff (!reset_n) // R10
    clk_en && afr_r[`UCPF_SEL_MSB:`UCPF_SEL_LSB] == 2'h3
    |=> multi_function_out_n == ~$past(mcr_r[`UCPF_MCR_OP2_BIT]))
    else $error("spare select not user output");

  // Ready select shows the inverted availability flag
  a_ready_pin: assert property (@(posedge clk) disable iff (!reset_n) // R5
    clk_en && afr_r[`UCPF_SEL_MSB:`UCPF_SEL_LSB] == 2'h2
    |=> multi_function_out_n == ~$past(rx_avail))
    else $error("ready pin wrong");
endmodule

// ---- verification/ucpf_line_model.sv ----
// Serial line and modem model at the far side of one channel
`timescale 1ns/1ns
module ucpf_line_model (
  input  wire logic       line_drive,
  input  wire logic       line_bit,
  input  wire logic [2:0] modem_n,
  output logic            serial_in,
  output logic            clear_send_n,
  output logic            set_ready_n,
  output logic            carrier_detect_n
);
  // Line rests high whenever no frame is being sent
  assign serial_in = line_drive ? line_bit : 1'b1;
  // Modem levels, active low, packed as {cd,dsr,cts}
  assign {carrier_detect_n, set_ready_n, clear_send_n} = modem_n;
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the pin function logic of one channel
`timescale 1ns/1ns
module tb;
  import ucpf_pkg::*;
  logic       clk = 0, reset_n = 0, clk_en = 1, afr_we = 0, mcr_we = 0;
  logic [7:0] afr_wdata = 8'h00, mcr_wdata = 8'h00, afr_q, mcr_q, row;
  logic       baud16 = 0, rx_avail = 0, tx_bit = 1, line_drive = 0, line_bit = 1;
  logic [2:0] modem_n = 3'h7, modem_in_status;
  logic       serial_in, clear_send_n, set_ready_n, carrier_detect_n;
  logic       mf_n, serial_out, request_send_n, terminal_ready_n, rx_bit;
  int         num_errors = 0, total_checks = 0;
  // Rows: select(2), op2, rts, dtr, baud16, rx_avail, expected pin
  logic [7:0] rows [8] = '{8'b00100000, 8'b00011111, 8'b01000100, 8'b01110011,
                           8'b10001010, 8'b10100101, 8'b11111000, 8'b11000111};
  // Free-running clock, 100 ns period
  always #50 clk = ~clk;
  ucpf_channel ucpf_channel_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .afr_we(afr_we), .afr_wdata(afr_wdata), .mcr_we(mcr_we), .mcr_wdata(mcr_wdata),
    .baud16(baud16), .rx_avail(rx_avail), .tx_bit(tx_bit), .serial_in(serial_in),
    .clear_send_n(clear_send_n), .set_ready_n(set_ready_n),
    .carrier_detect_n(carrier_detect_n), .multi_function_out_n(mf_n),
    .serial_out(serial_out), .request_send_n(request_send_n),
    .terminal_ready_n(terminal_ready_n), .rx_bit(rx_bit),
    .modem_in_status(modem_in_status), .afr_q(afr_q), .mcr_q(mcr_q));
  ucpf_line_model ucpf_line_model_inst (.line_drive(line_drive), .line_bit(line_bit),
    .modem_n(modem_n), .serial_in(serial_in), .clear_send_n(clear_send_n),
    .set_ready_n(set_ready_n), .carrier_detect_n(carrier_detect_n));
  // One compare, counted, with a short note on mismatch
  task automatic check(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  // Both registers written together; pin has settled two edges later
  task automatic wr(input logic [7:0] a, input logic [7:0] m);
    afr_wdata = a;
    mcr_wdata = m;
    afr_we = 1;
    mcr_we = 1;
    @(negedge clk);
    afr_we = 0;
    mcr_we = 0;
    repeat (2) @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog, far beyond the roughly 45 cycles the tests need
  initial begin
    #500000;
    num_errors++;
    $display("BAD %0t timeout", $time);
    print_verdict();
  end
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1;
    foreach (rows[i]) begin
      row = rows[i];
      baud16 = row[2];
      rx_avail = row[1];
      wr({5'h00, row[7:6], 1'b0}, {4'h0, row[5], 1'b0, row[4], row[3]});
      check(mf_n, row[0], "pin function");
      check(request_send_n, ~row[4], "send request");
      check(terminal_ready_n, ~row[3], "terminal ready");
    end
    $display("table done");
    // Pin follows a toggling baud clock, inverted, one edge behind
    wr(8'h02, 8'h08);
    repeat (4) begin
      baud16 = ~baud16;
      @(negedge clk);
      check(mf_n, ~baud16, "baud clock");
    end
    $display("baud done");
    // Modem inputs and line pins, with no effect on the registers
    modem_n = 3'h2;
    tx_bit = 0;
    line_drive = 1;
    line_bit = 0;
    repeat (4) @(negedge clk);
    check(modem_in_status === 3'h5, 1, "modem inputs");
    check(mcr_q === 8'h08 && afr_q === 8'h02, 1, "modem side effect");
    check(serial_out, 1'b0, "transmit pin");
    check(rx_bit, 1'b0, "receive pin");
    $display("pins done");
    // Writes ignored while the clock enable is low
    clk_en = 0;
    wr(8'h04, 8'h03);
    check(mcr_q === 8'h08 && afr_q === 8'h02, 1, "frozen");
    clk_en = 1;
    $display("freeze done");
    // Second reset in mid-run restores the defaults
    wr(8'h00, 8'h03);
    reset_n = 0;
    repeat (2) @(negedge clk);
    check(mcr_q === 8'h08 && afr_q === 8'h00, 1, "reset regs");
    check(mf_n, 1'b0, "reset pin");
    check(serial_out, 1'b1, "reset transmit");
    check(request_send_n & terminal_ready_n, 1'b1, "reset modem out");
    reset_n = 1;
    $display("reset done");
    print_verdict();
  end
endmodule
